// ### hw/sensor_ctrl_pkg.sv
// constants for the sensor control register group
package sensor_ctrl_pkg;
  localparam logic [7:0] SYS_CTRL_TWO_ADDR = 8'h2b;
  localparam logic [7:0] IRQ_WAKE_PIN_ADDR = 8'h2c;
  localparam logic [7:0] IRQ_SRC_EN_ADDR = 8'h2d;
  localparam logic [7:0] IRQ_ROUTING_ADDR = 8'h2e;
  localparam logic [7:0] SYS_CTRL_TWO_RESET = 8'h00;
  localparam logic [7:0] IRQ_WAKE_PIN_RESET = 8'h00;
  localparam logic [7:0] IRQ_SRC_EN_RESET = 8'h00;
  localparam logic [7:0] IRQ_ROUTING_RESET = 8'h00;
  // system control two fields
  localparam int SELF_TEST_BIT = 7;
  localparam int SOFT_RESET_BIT = 6;
  localparam int SLEEP_SCHEME_LSB = 3;
  localparam int AUTO_SLEEP_BIT = 2;
  localparam int WAKE_SCHEME_LSB = 0;
  // wake and pin control fields
  localparam int ORIENT_WAKE_BIT = 5;
  localparam int FFMT_WAKE_BIT = 3;
  localparam int POLARITY_BIT = 1;
  localparam int OUT_TYPE_BIT = 0;
  // source bit positions, shared by enable and routing registers
  localparam int SRC_SLEEP_BIT = 7;
  localparam int SRC_ORIENT_BIT = 4;
  localparam int SRC_FFMT_BIT = 2;
  localparam int SRC_DRDY_BIT = 0;
  localparam logic [7:0] SRC_MASK = 8'h95;
  // boot time after a software reset
  localparam int BOOT_TIME_NS = 1000;
  localparam int CLK_PERIOD_NS = 20;
  localparam int BOOT_CYCLES = (BOOT_TIME_NS + CLK_PERIOD_NS - 1) /
    CLK_PERIOD_NS;
  typedef enum logic [1:0] {
    SCHEME_NORMAL,
    SCHEME_LOW_NOISE,
    SCHEME_HIGH_RES,
    SCHEME_LOW_POWER
  } power_scheme_t;
  typedef enum logic [1:0] {
    MODE_STANDBY,
    MODE_WAKE,
    MODE_SLEEP
  } op_mode_t;
endpackage

// ### hw/irq_pin_driver.sv
// one interrupt pin with polarity and output type
`timescale 1ns/1ps
`default_nettype none
module irq_pin_driver
  import sensor_ctrl_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_sync_n,
  // configuration
  input wire logic active_high,
  input wire logic open_drain,
  // request
  input wire logic irq_active,
  // pad
  output logic pin_out,
  output logic pin_oe_n
);
  logic level_reg;
  logic level_next;
  logic oe_n_reg;
  logic oe_n_next;

  always_comb begin
    level_next = irq_active ~^ active_high;
    // open drain: drive only the low level, else release
    oe_n_next = open_drain & level_next;
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      level_reg <= 1'b1;
      oe_n_reg <= 1'b0;
    end else begin
      level_reg <= level_next;
      oe_n_reg <= oe_n_next;
    end
  end

  assign pin_out = level_reg;
  assign pin_oe_n = oe_n_reg;

  pin_level_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    1'b1 |=> pin_out == ($past(irq_active) ~^ $past(active_high)))
    else $error("interrupt pin level wrong");
endmodule
`default_nettype wire

// ### hw/sensor_system_interrupt_control.sv
// control register group of the accelerometer with interrupt pins
// Behaviour
// - self-test bit 7 of system control two shifts X, Y, Z outputs
// - soft reset bit 6 of system control two works in standby or active
// - writing 1 to reset bit resets at once and reloads all defaults
// - soft reset also resets the serial access logic
// - reset bit clears at end of boot; it always reads as zero
// - bits 4-3 select sleep power scheme, default 00
// - bits 1-0 select wake power scheme, default 00
// - scheme codes: 00 normal, 01 low noise, 10 high res, 11 low power
// - oversampling ratio per data rate and scheme follows the fixed table
// - bit 2 enables automatic sleep, off by default
// - bit 5 of pin control lets orientation wake the device
// - bit 3 of pin control lets freefall or motion wake the device
// - bit 1 sets pin polarity: 0 active low, 1 active high
// - bit 0 sets pin type: 0 push-pull, 1 open-drain
// - enables: sleep transition 7, orientation 4, freefall 2, ready 0
// - sources reach the controller only while enabled
// - routing bit 0 sends a source to pin two, 1 to pin one
// - with auto sleep on, wake needs both the source enable and its wake permission
// - without auto sleep the device never enters sleep
// - with its enable set, each wake/sleep change raises an interrupt
`timescale 1ns/1ps
`default_nettype none
module sensor_system_interrupt_control
  import sensor_ctrl_pkg::*;
#(
  parameter int BOOT_LEN = BOOT_CYCLES
)(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // register port from the serial interface
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic serial_reset,
  // operating mode and timing
  input wire logic active_mode,
  input wire logic sleep_timeout,
  input wire logic [2:0] data_rate,
  // pending events of the detection functions and their pin routing
  input wire logic orient_event,
  input wire logic ffmt_event,
  input wire logic drdy_event,
  input wire logic [7:0] routing,
  // controls toward the sensor core
  output logic self_test_enable,
  output logic [1:0] sleep_power_scheme,
  output logic [1:0] wake_power_scheme,
  output logic [10:0] oversample_ratio,
  output logic asleep,
  output logic booting,
  // interrupt pads
  output logic interrupt_pin_first_out,
  output logic interrupt_pin_first_oe_n,
  output logic interrupt_pin_second_out,
  output logic interrupt_pin_second_oe_n
);
  logic rst_meta_reg;
  logic rst_sync_n;
  logic [7:0] ctrl_two_reg;
  logic [7:0] ctrl_two_next;
  logic [7:0] pin_ctrl_reg;
  logic [7:0] pin_ctrl_next;
  logic [7:0] src_en_reg;
  logic [7:0] src_en_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [$clog2(BOOT_LEN+1)-1:0] boot_cnt_reg;
  logic [$clog2(BOOT_LEN+1)-1:0] boot_cnt_next;
  op_mode_t mode_reg;
  op_mode_t mode_next;
  logic sleep_flag_reg;
  logic sleep_flag_next;
  logic soft_reset_req;
  logic wake_req;
  logic [7:0] pending;
  logic first_active;
  logic second_active;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_n <= rst_meta_reg;
    end
  end

  // oversampling ratio lookup
  function automatic logic [10:0] os_ratio(input logic [2:0] rate,
                                           input logic [1:0] scheme);
    logic [10:0] r;
    r = 11'h002;
    case (scheme)
      SCHEME_NORMAL: begin
        if (rate == 3'h7)
          r = 11'h080;
        else if (rate != 3'h0)
          r = 11'h004;
      end
      SCHEME_LOW_NOISE: begin
        if (rate == 3'h7)
          r = 11'h020;
        else if (rate != 3'h0)
          r = 11'h004;
      end
      SCHEME_HIGH_RES: begin
        case (rate)
          3'h0: r = 11'h002;
          3'h1: r = 11'h004;
          3'h2: r = 11'h008;
          3'h3: r = 11'h010;
          3'h7: r = 11'h400;
          default: r = 11'h020;
        endcase
      end
      default: begin
        if (rate == 3'h7)
          r = 11'h010;
      end
    endcase
    return r;
  endfunction

  assign soft_reset_req = reg_wr && reg_addr == SYS_CTRL_TWO_ADDR &&
    reg_wdata[SOFT_RESET_BIT];

  // register writes and boot sequence
  always_comb begin
    ctrl_two_next = ctrl_two_reg;
    pin_ctrl_next = pin_ctrl_reg;
    src_en_next = src_en_reg;
    boot_cnt_next = boot_cnt_reg;
    if (soft_reset_req) begin
      ctrl_two_next = SYS_CTRL_TWO_RESET | (8'h01 << SOFT_RESET_BIT);
      pin_ctrl_next = IRQ_WAKE_PIN_RESET;
      src_en_next = IRQ_SRC_EN_RESET;
      boot_cnt_next = BOOT_LEN[$bits(boot_cnt_reg)-1:0];
    end else if (boot_cnt_reg != '0) begin
      boot_cnt_next = boot_cnt_reg - 1'b1;
      if (boot_cnt_reg == 1)
        ctrl_two_next[SOFT_RESET_BIT] = 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == SYS_CTRL_TWO_ADDR)
        ctrl_two_next = reg_wdata;
      else if (reg_addr == IRQ_WAKE_PIN_ADDR)
        pin_ctrl_next = reg_wdata;
      else if (reg_addr == IRQ_SRC_EN_ADDR)
        src_en_next = reg_wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ctrl_two_reg <= SYS_CTRL_TWO_RESET;
      pin_ctrl_reg <= IRQ_WAKE_PIN_RESET;
      src_en_reg <= IRQ_SRC_EN_RESET;
      boot_cnt_reg <= '0;
    end else begin
      ctrl_two_reg <= ctrl_two_next;
      pin_ctrl_reg <= pin_ctrl_next;
      src_en_reg <= src_en_next;
      boot_cnt_reg <= boot_cnt_next;
    end
  end

  // read data
  always_comb begin
    rdata_next = rdata_reg;
    if (reg_rd) begin
      if (reg_addr == SYS_CTRL_TWO_ADDR)
        rdata_next = ctrl_two_reg & ~(8'h01 << SOFT_RESET_BIT);
      else if (reg_addr == IRQ_WAKE_PIN_ADDR)
        rdata_next = pin_ctrl_reg;
      else if (reg_addr == IRQ_SRC_EN_ADDR)
        rdata_next = src_en_reg;
      else
        rdata_next = 8'h00;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n)
      rdata_reg <= 8'h00;
    else
      rdata_reg <= rdata_next;
  end

  // wake and sleep sequencing
  assign wake_req = (src_en_reg[SRC_ORIENT_BIT] &
    pin_ctrl_reg[ORIENT_WAKE_BIT] & orient_event) |
    (src_en_reg[SRC_FFMT_BIT] & pin_ctrl_reg[FFMT_WAKE_BIT] &
    ffmt_event);

  always_comb begin
    mode_next = mode_reg;
    sleep_flag_next = sleep_flag_reg;
    if (!src_en_reg[SRC_SLEEP_BIT])
      sleep_flag_next = 1'b0;
    case (mode_reg)
      MODE_STANDBY: begin
        if (active_mode)
          mode_next = MODE_WAKE;
      end
      MODE_WAKE: begin
        if (!active_mode)
          mode_next = MODE_STANDBY;
        else if (ctrl_two_reg[AUTO_SLEEP_BIT] && sleep_timeout) begin
          mode_next = MODE_SLEEP;
          sleep_flag_next = src_en_reg[SRC_SLEEP_BIT];
        end
      end
      default: begin
        if (!active_mode)
          mode_next = MODE_STANDBY;
        else if (wake_req || !ctrl_two_reg[AUTO_SLEEP_BIT]) begin
          mode_next = MODE_WAKE;
          sleep_flag_next = src_en_reg[SRC_SLEEP_BIT];
        end
      end
    endcase
    if (soft_reset_req) begin
      mode_next = MODE_STANDBY;
      sleep_flag_next = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      mode_reg <= MODE_STANDBY;
      sleep_flag_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      sleep_flag_reg <= sleep_flag_next;
    end
  end

  // interrupt gating and routing
  always_comb begin
    pending = 8'h00;
    pending[SRC_SLEEP_BIT] = sleep_flag_reg;
    pending[SRC_ORIENT_BIT] = orient_event;
    pending[SRC_FFMT_BIT] = ffmt_event;
    pending[SRC_DRDY_BIT] = drdy_event;
    pending = pending & src_en_reg & SRC_MASK;
    first_active = |(pending & routing);
    second_active = |(pending & ~routing);
  end

  irq_pin_driver first_pin (
    .ref_clk(ref_clk),
    .rst_sync_n(rst_sync_n),
    .active_high(pin_ctrl_reg[POLARITY_BIT]),
    .open_drain(pin_ctrl_reg[OUT_TYPE_BIT]),
    .irq_active(first_active),
    .pin_out(interrupt_pin_first_out),
    .pin_oe_n(interrupt_pin_first_oe_n)
  );

  irq_pin_driver second_pin (
    .ref_clk(ref_clk),
    .rst_sync_n(rst_sync_n),
    .active_high(pin_ctrl_reg[POLARITY_BIT]),
    .open_drain(pin_ctrl_reg[OUT_TYPE_BIT]),
    .irq_active(second_active),
    .pin_out(interrupt_pin_second_out),
    .pin_oe_n(interrupt_pin_second_oe_n)
  );

  assign reg_rdata = rdata_reg;
  assign booting = boot_cnt_reg != '0;
  assign serial_reset = booting;
  assign self_test_enable = ctrl_two_reg[SELF_TEST_BIT];
  assign sleep_power_scheme = ctrl_two_reg[SLEEP_SCHEME_LSB +: 2];
  assign wake_power_scheme = ctrl_two_reg[WAKE_SCHEME_LSB +: 2];
  assign asleep = mode_reg == MODE_SLEEP;
  assign oversample_ratio = os_ratio(data_rate,
    asleep ? sleep_power_scheme : wake_power_scheme);

  sequence reset_write_s;
    soft_reset_req;
  endsequence
  sequence defaults_loaded_s;
    pin_ctrl_reg == IRQ_WAKE_PIN_RESET && src_en_reg == IRQ_SRC_EN_RESET;
  endsequence

  soft_reset_defaults_a: assert property (@(posedge ref_clk)
    disable iff (!rst_sync_n) reset_write_s |=> defaults_loaded_s
    and (booting && mode_reg == MODE_STANDBY))
    else $error("soft reset did not reload defaults");
  serial_reset_hold_a: assert property (@(posedge ref_clk)
    disable iff (!rst_sync_n) soft_reset_req |=> serial_reset &&
    boot_cnt_reg == BOOT_LEN)
    else $error("serial logic not held in reset");
  boot_write_block_a: assert property (@(posedge ref_clk)
    disable iff (!rst_sync_n) booting && reg_wr && !soft_reset_req
    |=> $stable(pin_ctrl_reg) && $stable(src_en_reg))
    else $error("register written during boot");
  reset_reads_zero_a: assert property (@(posedge ref_clk)
    disable iff (!rst_sync_n) reg_rd && reg_addr == SYS_CTRL_TWO_ADDR
    |=> !reg_rdata[SOFT_RESET_BIT])
    else $error("reset bit read back as one");
  no_sleep_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    !ctrl_two_reg[AUTO_SLEEP_BIT] && mode_reg != MODE_SLEEP
    |=> mode_reg != MODE_SLEEP)
    else $error("entered sleep with auto sleep off");
  wake_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    mode_reg == MODE_SLEEP && active_mode && ctrl_two_reg[AUTO_SLEEP_BIT]
    && !wake_req && !soft_reset_req |=> mode_reg == MODE_SLEEP)
    else $error("woke without permitted source");
  sleep_irq_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    src_en_reg[SRC_SLEEP_BIT] && !soft_reset_req &&
    mode_reg == MODE_WAKE && mode_next == MODE_SLEEP |=> sleep_flag_reg)
    else $error("sleep change raised no interrupt");
  enable_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    src_en_reg == 8'h00 |-> !first_active && !second_active)
    else $error("disabled source reached a pin");
  routing_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    src_en_reg[SRC_DRDY_BIT] && drdy_event && !routing[SRC_DRDY_BIT]
    |-> second_active)
    else $error("routing zero missed second pin");
  ratio_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    data_rate == 3'h7 && !asleep && wake_power_scheme == SCHEME_HIGH_RES
    |-> oversample_ratio == 11'h400)
    else $error("oversample ratio wrong");
endmodule
`default_nettype wire

// ### testbench/host_access_model.sv
// host side model issuing single byte register accesses
`timescale 1ns/1ps
`default_nettype none
module host_access_model (
  // clock
  input wire logic ref_clk,
  // register port
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    // released bus shows no stale value
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// ### testbench/sensor_system_interrupt_control_bench.sv
// self-checking bench for the control register group
`timescale 1ns/1ps
`default_nettype none
module sensor_system_interrupt_control_bench;
  import sensor_ctrl_pkg::*;
  localparam int BOOT = 4;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr, reg_rd;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic serial_reset, self_test_enable, asleep, booting;
  logic active_mode = 1'b0;
  logic sleep_timeout = 1'b0;
  logic [2:0] data_rate = 3'h0;
  logic orient_event = 1'b0;
  logic ffmt_event = 1'b0;
  logic drdy_event = 1'b0;
  logic [7:0] routing = 8'h00;
  logic [1:0] sleep_power_scheme, wake_power_scheme;
  logic [10:0] oversample_ratio;
  logic p1_out, p1_oe_n, p2_out, p2_oe_n;
  int failures = 0;
  int samples_checked = 0;
  always #10 ref_clk = ~ref_clk;
  host_access_model host (.ref_clk(ref_clk), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata));
  sensor_system_interrupt_control #(.BOOT_LEN(BOOT)) uut (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .serial_reset(serial_reset), .active_mode(active_mode),
    .sleep_timeout(sleep_timeout), .data_rate(data_rate),
    .orient_event(orient_event), .ffmt_event(ffmt_event),
    .drdy_event(drdy_event), .routing(routing),
    .self_test_enable(self_test_enable),
    .sleep_power_scheme(sleep_power_scheme),
    .wake_power_scheme(wake_power_scheme),
    .oversample_ratio(oversample_ratio), .asleep(asleep),
    .booting(booting), .interrupt_pin_first_out(p1_out),
    .interrupt_pin_first_oe_n(p1_oe_n),
    .interrupt_pin_second_out(p2_out),
    .interrupt_pin_second_oe_n(p2_oe_n));
  task automatic chk(input string n, input logic [10:0] e,
                     input logic [10:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    chk("reg_rdata", {3'h0, e}, {3'h0, d});
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic t_reset_values();
    rchk(SYS_CTRL_TWO_ADDR, 8'h00);
    rchk(IRQ_WAKE_PIN_ADDR, 8'h00);
    rchk(IRQ_SRC_EN_ADDR, 8'h00);
    rchk(8'h10, 8'h00);
    chk("pin_first_out", 11'h1, {10'h0, p1_out});
    chk("pin_first_oe_n", 11'h0, {10'h0, p1_oe_n});
  endtask
  task automatic t_ctrl_two();
    host.wr(SYS_CTRL_TWO_ADDR, 8'h9d);
    rchk(SYS_CTRL_TWO_ADDR, 8'h9d);
    rchk(8'h10, 8'h00);
    chk("self_test", 11'h1, {10'h0, self_test_enable});
    chk("sleep_scheme", 11'h3, {9'h0, sleep_power_scheme});
    chk("wake_scheme", 11'h1, {9'h0, wake_power_scheme});
    host.wr(SYS_CTRL_TWO_ADDR, 8'h00);
  endtask
  task automatic t_ratio();
    logic [10:0] r7 [4] = '{11'd128, 11'd32, 11'd1024, 11'd16};
    logic [10:0] r1 [4] = '{11'd4, 11'd4, 11'd4, 11'd2};
    active_mode = 1'b1;
    for (int s = 0; s < 4; s++) begin
      host.wr(SYS_CTRL_TWO_ADDR, {3'h0, ~s[1:0], 1'b0, s[1:0]});
      data_rate = 3'h7;
      settle(1);
      chk("ratio_slow", r7[s], oversample_ratio);
      data_rate = 3'h1;
      settle(1);
      chk("ratio_400", r1[s], oversample_ratio);
      data_rate = 3'h0;
      settle(1);
      chk("ratio_800", 11'd2, oversample_ratio);
    end
    host.wr(SYS_CTRL_TWO_ADDR, 8'h00);
  endtask
  task automatic t_pins();
    routing = 8'h01;
    drdy_event = 1'b1;
    host.wr(IRQ_SRC_EN_ADDR, 8'h01);
    settle(3);
    chk("first_low", 11'h0, {10'h0, p1_out});
    chk("second_idle", 11'h1, {10'h0, p2_out});
    host.wr(IRQ_WAKE_PIN_ADDR, 8'h02);
    settle(3);
    chk("first_high", 11'h1, {10'h0, p1_out});
    chk("second_high", 11'h0, {10'h0, p2_out});
    host.wr(IRQ_WAKE_PIN_ADDR, 8'h01);
    settle(3);
    chk("first_od", 11'h0, {9'h0, p1_out, p1_oe_n});
    chk("second_od", 11'h1, {10'h0, p2_oe_n});
    routing = 8'h00;
    settle(3);
    chk("route_second", 11'h0, {9'h0, p2_out, p2_oe_n});
    chk("route_first", 11'h1, {10'h0, p1_oe_n});
    host.wr(IRQ_SRC_EN_ADDR, 8'h00);
    settle(3);
    chk("disabled", 11'h1, {10'h0, p2_oe_n});
    drdy_event = 1'b0;
    host.wr(IRQ_WAKE_PIN_ADDR, 8'h00);
  endtask
  task automatic t_sleep();
    sleep_timeout = 1'b1;
    settle(10);
    chk("no_auto_sleep", 11'h0, {10'h0, asleep});
    routing = 8'h80;
    host.wr(IRQ_SRC_EN_ADDR, 8'h84);
    host.wr(SYS_CTRL_TWO_ADDR, 8'h04);
    settle(5);
    chk("asleep", 11'h1, {10'h0, asleep});
    chk("sleep_irq", 11'h0, {10'h0, p1_out});
    sleep_timeout = 1'b0;
    ffmt_event = 1'b1;
    settle(5);
    chk("no_wake_perm", 11'h1, {10'h0, asleep});
    host.wr(IRQ_WAKE_PIN_ADDR, 8'h08);
    settle(5);
    chk("ffmt_wake", 11'h0, {10'h0, asleep});
    ffmt_event = 1'b0;
    sleep_timeout = 1'b1;
    host.wr(IRQ_SRC_EN_ADDR, 8'h94);
    host.wr(IRQ_WAKE_PIN_ADDR, 8'h20);
    settle(5);
    chk("asleep_again", 11'h1, {10'h0, asleep});
    sleep_timeout = 1'b0;
    orient_event = 1'b1;
    settle(5);
    chk("orient_wake", 11'h0, {10'h0, asleep});
    orient_event = 1'b0;
  endtask
  task automatic t_soft_reset();
    host.wr(IRQ_WAKE_PIN_ADDR, 8'h03);
    host.wr(IRQ_SRC_EN_ADDR, 8'h95);
    host.wr(SYS_CTRL_TWO_ADDR, 8'hc4);
    chk("booting", 11'h1, {10'h0, booting});
    chk("serial_reset", 11'h1, {10'h0, serial_reset});
    chk("self_test_clr", 11'h0, {10'h0, self_test_enable});
    rchk(SYS_CTRL_TWO_ADDR, 8'h00);
    host.wr(IRQ_SRC_EN_ADDR, 8'h01);
    settle(BOOT + 2);
    chk("boot_done", 11'h0, {10'h0, booting});
    rchk(SYS_CTRL_TWO_ADDR, 8'h00);
    rchk(IRQ_WAKE_PIN_ADDR, 8'h00);
    rchk(IRQ_SRC_EN_ADDR, 8'h00);
  endtask
  task automatic final_report();
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge ref_clk);
    failures++;
    final_report();
  end
  initial begin
    settle(20);
    rst_n = 1'b1;
    settle(4);
    t_reset_values();
    t_ctrl_two();
    t_ratio();
    t_pins();
    t_sleep();
    t_soft_reset();
    final_report();
  end
endmodule
`default_nettype wire
